// ---- common/adcsc_defs.vh ----
`ifndef ADCSC_DEFS_VH
`define ADCSC_DEFS_VH

// Register byte offsets
`define ADCSC_OFS_STATUS       8'h00
`define ADCSC_OFS_CONTROL      8'h04

// Reset values
`define ADCSC_RST_STATUS       32'h00000000
`define ADCSC_RST_CONTROL      32'h00000000

// Status field positions
`define ADCSC_ST_WIN1_EVT      30
`define ADCSC_ST_RSTART        4
`define ADCSC_ST_SEQ_DONE      1
`define ADCSC_ST_WIN0_EVT      0

// Control field positions
`define ADCSC_CT_WIN1_IE       30
`define ADCSC_CT_RWIN0_EN      23
`define ADCSC_CT_SYNC_HI       19
`define ADCSC_CT_SYNC_LO       16
`define ADCSC_CT_DISC_HI       15
`define ADCSC_CT_DISC_LO       13
`define ADCSC_CT_DISC_EN       11
`define ADCSC_CT_WIN0_SINGLE   9
`define ADCSC_CT_SCAN_EN       8
`define ADCSC_CT_WIN0_IE       6
`define ADCSC_CT_SEQ_IE        5
`define ADCSC_CT_CHSEL_HI      4
`define ADCSC_CT_CHSEL_LO      0

// Sync mode codes
`define ADCSC_SYNC_FREE        4'h0
`define ADCSC_SYNC_PARALLEL    4'h6
`define ADCSC_SYNC_FOLLOW_FAST 4'h7
`define ADCSC_SYNC_FOLLOW_SLOW 4'h8

// Highest legal watchdog channel index
`define ADCSC_CHSEL_MAX        5'h11

`endif

// ---- design/adcsc_window.v ----
`timescale 1ns/1ps
`default_nettype none

module adcsc_window #(
  parameter DW = 12
) (
  // Clock and reset
  input  wire          mclk_i,
  input  wire          rst_n_i,
  // Configuration
  input  wire          check_en_i,
  input  wire          single_i,
  input  wire [4:0]    chsel_i,
  input  wire [DW-1:0] low_i,
  input  wire [DW-1:0] high_i,
  // Converted sample
  input  wire          smp_vld_i,
  input  wire [4:0]    smp_ch_i,
  input  wire [DW-1:0] smp_val_i,
  // Event pulse
  output wire          event_o
);

  reg  event_ff;
  wire ch_hit;
  wire outside;

  // Single channel mode narrows the check to one channel
  assign ch_hit  = !single_i || (smp_ch_i == chsel_i);
  assign outside = (smp_val_i < low_i) || (smp_val_i > high_i);

  // One-cycle event when a checked sample leaves the window
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      event_ff <= 1'b0;
    else
      event_ff <= smp_vld_i && check_en_i && ch_hit && outside;
  end

  assign event_o = event_ff;

endmodule
`default_nettype wire

// ---- design/adcsc_regs.v ----
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defs.vh"

// What this block does
// - Interrupt from sequence end and both watchdogs
// - Both converter requests share one interrupt line
// - Watchdog 1 crossing sets status bit 30
// - Routine conversion start sets status bit 4
// - Sequence end sets bit 1; data read clears
// - Watchdog 0 crossing sets status bit 0
// - Control bit 30 enables watchdog 1 interrupt
// - Control bit 23 enables watchdog 0 on routine
// - Bits 19:16 select dual converter sync mode
// - Sync select works only in primary instance
// - Discontinuous converts count field plus one channels
// - Control bit 11 enables discontinuous mode
// - Control bit 9 limits watchdog 0 to one channel
// - Control bit 8 enables scan mode
// - Control bit 6 enables watchdog 0 interrupt
// - Control bit 5 enables sequence end interrupt
// - Bits 4:0 pick watchdog 0 channel 0..17
module adcsc_regs #(
  parameter DW         = 12,
  parameter IS_PRIMARY = 1
) (
  // Clock and reset
  input  wire          mclk_i,
  input  wire          rst_n_i,
  // AHB-Lite slave
  input  wire          hsel_i,
  input  wire [7:0]    haddr_i,
  input  wire [1:0]    htrans_i,
  input  wire          hwrite_i,
  input  wire [2:0]    hsize_i,
  input  wire [31:0]   hwdata_i,
  input  wire          hready_i,
  output wire [31:0]   hrdata_o,
  output wire          hreadyout_o,
  output wire          hresp_o,
  // Sequencing core events
  input  wire          rstart_pulse_i,
  input  wire          seq_done_pulse_i,
  input  wire          rdata_read_pulse_i,
  input  wire          smp_vld_i,
  input  wire [4:0]    smp_ch_i,
  input  wire [DW-1:0] smp_val_i,
  // Watchdog thresholds
  input  wire [DW-1:0] win0_low_i,
  input  wire [DW-1:0] win0_high_i,
  input  wire [DW-1:0] win1_low_i,
  input  wire [DW-1:0] win1_high_i,
  // Interrupt merge
  input  wire          peer_irq_i,
  output wire          irq_o,
  // Sequencer configuration
  output wire          scan_enable_o,
  output wire          disc_enable_o,
  output wire [3:0]    disc_per_trigger_o,
  output wire [3:0]    sync_select_o
);

  localparam [7:0] A_ST = `ADCSC_OFS_STATUS;
  localparam [7:0] A_CT = `ADCSC_OFS_CONTROL;

  // Bus phase states
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_WRITE = 2'h1;
  localparam [1:0] S_RWAIT = 2'h2;

  // Bus state
  reg  [1:0]  bus_state_ff;
  reg  [1:0]  nxt_bus_state;
  reg  [7:0]  addr_ff;
  reg         hready_ff;
  reg  [31:0] hrdata_ff;
  reg  [31:0] nxt_hrdata;

  // Status flags
  reg  win1_evt_ff;
  reg  rstart_ff;
  reg  seq_done_ff;
  reg  win0_evt_ff;

  // Control fields
  reg         win1_ie_ff;
  reg         rwin0_en_ff;
  reg  [3:0]  sync_ff;
  reg  [2:0]  disc_cnt_ff;
  reg         disc_en_ff;
  reg         win0_single_ff;
  reg         scan_en_ff;
  reg         win0_ie_ff;
  reg         seq_ie_ff;
  reg  [4:0]  chsel_ff;

  // Registered outputs
  reg         irq_ff;
  reg         scan_out_ff;
  reg         disc_out_ff;
  reg  [3:0]  disc_num_ff;
  reg  [3:0]  sync_out_ff;

  wire        take;
  wire        wr_st;
  wire        wr_ct;
  wire        win0_evt;
  wire        win1_evt;
  wire        sync_legal;
  wire [3:0]  sync_wr;
  wire        local_req;

  // Address phase accepted only on a real transfer
  assign take  = hsel_i && htrans_i[1] && hready_i;
  assign wr_st = (bus_state_ff == S_WRITE) && (addr_ff == A_ST);
  assign wr_ct = (bus_state_ff == S_WRITE) && (addr_ff == A_CT);

  // Bus phase sequencing; reads wait one cycle so a
  // write just ahead of them is already visible
  always @*
  begin
    nxt_bus_state = S_IDLE;
    if (bus_state_ff == S_RWAIT)
      nxt_bus_state = S_IDLE;
    else if (take)
      nxt_bus_state = hwrite_i ? S_WRITE : S_RWAIT;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      bus_state_ff <= S_IDLE;
      addr_ff      <= 8'h00;
      hready_ff    <= 1'b1;
    end
    else
    begin
      bus_state_ff <= nxt_bus_state;
      if (take && bus_state_ff != S_RWAIT)
        addr_ff <= {haddr_i[7:2], 2'b00};
      hready_ff <= (nxt_bus_state != S_RWAIT);
    end
  end

  // Read mux; unmapped words and reserved bits read zero
  always @*
  begin
    nxt_hrdata = 32'h00000000;
    case (addr_ff)
      A_ST:
      begin
        nxt_hrdata[`ADCSC_ST_WIN1_EVT] = win1_evt_ff;
        nxt_hrdata[`ADCSC_ST_RSTART]   = rstart_ff;
        nxt_hrdata[`ADCSC_ST_SEQ_DONE] = seq_done_ff;
        nxt_hrdata[`ADCSC_ST_WIN0_EVT] = win0_evt_ff;
      end
      A_CT:
      begin
        nxt_hrdata[`ADCSC_CT_WIN1_IE]     = win1_ie_ff;
        nxt_hrdata[`ADCSC_CT_RWIN0_EN]    = rwin0_en_ff;
        nxt_hrdata[`ADCSC_CT_SYNC_HI:`ADCSC_CT_SYNC_LO] = sync_ff;
        nxt_hrdata[`ADCSC_CT_DISC_HI:`ADCSC_CT_DISC_LO] = disc_cnt_ff;
        nxt_hrdata[`ADCSC_CT_DISC_EN]     = disc_en_ff;
        nxt_hrdata[`ADCSC_CT_WIN0_SINGLE] = win0_single_ff;
        nxt_hrdata[`ADCSC_CT_SCAN_EN]     = scan_en_ff;
        nxt_hrdata[`ADCSC_CT_WIN0_IE]     = win0_ie_ff;
        nxt_hrdata[`ADCSC_CT_SEQ_IE]      = seq_ie_ff;
        nxt_hrdata[`ADCSC_CT_CHSEL_HI:`ADCSC_CT_CHSEL_LO] = chsel_ff;
      end
      default:
        nxt_hrdata = 32'h00000000;
    endcase
  end

  // Read data captured at the end of the wait cycle
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      hrdata_ff <= 32'h00000000;
    else if (bus_state_ff == S_RWAIT)
      hrdata_ff <= nxt_hrdata;
  end

  // Watchdog 0 checks routine results when enabled
  adcsc_window #(
    .DW (DW)
  ) u_win0 (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .check_en_i (rwin0_en_ff),
    .single_i   (win0_single_ff),
    .chsel_i    (chsel_ff),
    .low_i      (win0_low_i),
    .high_i     (win0_high_i),
    .smp_vld_i  (smp_vld_i),
    .smp_ch_i   (smp_ch_i),
    .smp_val_i  (smp_val_i),
    .event_o    (win0_evt)
  );

  // Watchdog 1 watches every channel against its pair
  adcsc_window #(
    .DW (DW)
  ) u_win1 (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .check_en_i (1'b1),
    .single_i   (1'b0),
    .chsel_i    (5'h00),
    .low_i      (win1_low_i),
    .high_i     (win1_high_i),
    .smp_vld_i  (smp_vld_i),
    .smp_ch_i   (smp_ch_i),
    .smp_val_i  (smp_val_i),
    .event_o    (win1_evt)
  );

  // Status flags: hardware set beats a clear in the same cycle;
  // writing one leaves a flag as it was
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      win1_evt_ff <= 1'b0;
      rstart_ff   <= 1'b0;
      seq_done_ff <= 1'b0;
      win0_evt_ff <= 1'b0;
    end
    else
    begin
      if (win1_evt)
        win1_evt_ff <= 1'b1;
      else if (wr_st && !hwdata_i[`ADCSC_ST_WIN1_EVT])
        win1_evt_ff <= 1'b0;
      if (rstart_pulse_i)
        rstart_ff <= 1'b1;
      else if (wr_st && !hwdata_i[`ADCSC_ST_RSTART])
        rstart_ff <= 1'b0;
      if (seq_done_pulse_i)
        seq_done_ff <= 1'b1;
      else if (rdata_read_pulse_i)
        seq_done_ff <= 1'b0;
      else if (wr_st && !hwdata_i[`ADCSC_ST_SEQ_DONE])
        seq_done_ff <= 1'b0;
      if (win0_evt)
        win0_evt_ff <= 1'b1;
      else if (wr_st && !hwdata_i[`ADCSC_ST_WIN0_EVT])
        win0_evt_ff <= 1'b0;
    end
  end

  // Only documented sync codes are stored
  assign sync_wr    = hwdata_i[`ADCSC_CT_SYNC_HI:`ADCSC_CT_SYNC_LO];
  assign sync_legal = (sync_wr == `ADCSC_SYNC_FREE) ||
                      (sync_wr == `ADCSC_SYNC_PARALLEL) ||
                      (sync_wr == `ADCSC_SYNC_FOLLOW_FAST) ||
                      (sync_wr == `ADCSC_SYNC_FOLLOW_SLOW);

  // Control register
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      win1_ie_ff     <= 1'b0;
      rwin0_en_ff    <= 1'b0;
      sync_ff        <= `ADCSC_SYNC_FREE;
      disc_cnt_ff    <= 3'h0;
      disc_en_ff     <= 1'b0;
      win0_single_ff <= 1'b0;
      scan_en_ff     <= 1'b0;
      win0_ie_ff     <= 1'b0;
      seq_ie_ff      <= 1'b0;
      chsel_ff       <= 5'h00;
    end
    else if (wr_ct)
    begin
      win1_ie_ff     <= hwdata_i[`ADCSC_CT_WIN1_IE];
      rwin0_en_ff    <= hwdata_i[`ADCSC_CT_RWIN0_EN];
      if (sync_legal)
        sync_ff <= sync_wr;
      disc_cnt_ff    <=
        hwdata_i[`ADCSC_CT_DISC_HI:`ADCSC_CT_DISC_LO];
      disc_en_ff     <= hwdata_i[`ADCSC_CT_DISC_EN];
      win0_single_ff <= hwdata_i[`ADCSC_CT_WIN0_SINGLE];
      scan_en_ff     <= hwdata_i[`ADCSC_CT_SCAN_EN];
      win0_ie_ff     <= hwdata_i[`ADCSC_CT_WIN0_IE];
      seq_ie_ff      <= hwdata_i[`ADCSC_CT_SEQ_IE];
      // Reserved channel codes are refused, old pick stays
      if (hwdata_i[`ADCSC_CT_CHSEL_HI:`ADCSC_CT_CHSEL_LO]
          <= `ADCSC_CHSEL_MAX)
        chsel_ff <=
          hwdata_i[`ADCSC_CT_CHSEL_HI:`ADCSC_CT_CHSEL_LO];
    end
  end

  // Level request while any enabled flag is set
  assign local_req = (win1_evt_ff && win1_ie_ff) ||
                     (seq_done_ff && seq_ie_ff) ||
                     (win0_evt_ff && win0_ie_ff);

  // Registered outputs; the peer request joins the same line
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_ff      <= 1'b0;
      scan_out_ff <= 1'b0;
      disc_out_ff <= 1'b0;
      disc_num_ff <= 4'h1;
      sync_out_ff <= `ADCSC_SYNC_FREE;
    end
    else
    begin
      irq_ff      <= local_req || peer_irq_i;
      scan_out_ff <= scan_en_ff;
      disc_out_ff <= disc_en_ff;
      disc_num_ff <= {1'b0, disc_cnt_ff} + 4'h1;
      // Secondary instance never drives a sync mode
      sync_out_ff <= (IS_PRIMARY != 0) ? sync_ff
                                       : `ADCSC_SYNC_FREE;
    end
  end

  // Bus answers
  assign hrdata_o    = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o     = 1'b0;

  // Interrupt and sequencer configuration
  assign irq_o              = irq_ff;
  assign scan_enable_o      = scan_out_ff;
  assign disc_enable_o      = disc_out_ff;
  assign disc_per_trigger_o = disc_num_ff;
  assign sync_select_o      = sync_out_ff;

endmodule
`default_nettype wire

// ---- dv/adcsc_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_regs_chk #(
  parameter IS_PRIMARY = 1
) (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [7:0]  haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  // Interrupt and configuration
  input wire logic        peer_irq_i,
  input wire logic        irq_o,
  input wire logic        scan_enable_o,
  input wire logic        disc_enable_o,
  input wire logic [3:0]  disc_per_trigger_o,
  input wire logic [3:0]  sync_select_o
);
  logic take;
  logic wr_ctl_ff;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Accepted address phase
  assign take = hsel_i & htrans_i[1] & hready_i;
  // Control write in its data phase; cleared by reset
  always @(posedge mclk_i)
    wr_ctl_ff <= rst_n_i & take & hwrite_i & (haddr_i[7:2] == 6'h01);
  // Field lands at the end of the data phase, output one edge later
  AST_SCAN: assert property (
    wr_ctl_ff |=> ##1 scan_enable_o == $past(hwdata_i[8], 2))
    else $error("scan enable does not follow write");
  AST_DISC_EN: assert property (
    wr_ctl_ff |=> ##1 disc_enable_o == $past(hwdata_i[11], 2))
    else $error("discontinuous enable does not follow write");
  AST_DISC_CNT: assert property (
    wr_ctl_ff |=> ##1
      disc_per_trigger_o == {1'b0, $past(hwdata_i[15:13], 2)} + 4'h1)
    else $error("channels per trigger wrong");
  AST_SYNC_CODE: assert property (
    sync_select_o inside {4'h0, 4'h6, 4'h7, 4'h8})
    else $error("reserved sync code selected");
  AST_SYNC_SEC: assert property (
    (IS_PRIMARY != 0) || (sync_select_o == 4'h0))
    else $error("sync select active in secondary");
  AST_PEER: assert property (
    peer_irq_i |=> irq_o)
    else $error("peer request not merged");
  AST_PEER_HOLD: assert property (
    $fell(irq_o) |-> !$past(peer_irq_i))
    else $error("interrupt dropped while peer requests");
  AST_CFG_STABLE: assert property (
    !$stable({scan_enable_o, disc_enable_o, disc_per_trigger_o})
      |-> $past(wr_ctl_ff, 2))
    else $error("configuration changed without write");
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rst_n, hsel, hwrite, hrdy, peer, irq, scan, disc, r;
  logic        hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [3:0]  pls, dpt, sync;
  logic [4:0]  ch;
  logic [11:0] val, w0lo, w0hi, w1lo, w1hi;
  logic [3:0]  codes [0:2];
  integer      n_mismatch, tests_run, i;
  // Window thresholds driven by the bench
  adcsc_regs #(.DW(12), .IS_PRIMARY(1)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .rstart_pulse_i(pls[3]),
    .seq_done_pulse_i(pls[2]), .rdata_read_pulse_i(pls[1]),
    .smp_vld_i(pls[0]), .smp_ch_i(ch), .smp_val_i(val),
    .win0_low_i(w0lo), .win0_high_i(w0hi), .win1_low_i(w1lo),
    .win1_high_i(w1hi), .peer_irq_i(peer), .irq_o(irq),
    .scan_enable_o(scan), .disc_enable_o(disc),
    .disc_per_trigger_o(dpt), .sync_select_o(sync));
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        $display("[FAIL] %s exp %h got %h", n, e, g);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  // Wait for hready at a rising edge; ready sampled before the edge
  task hs;
    integer k;
    begin
      k = 0;
      r = 1'b0;
      while (!r)
      begin
        @(negedge mclk);
        r = hrdy;
        q = hrdata;
        k = k + 1;
        if (k > 40)
        begin
          n_mismatch = n_mismatch + 1;
          finish_test;
        end
        @(posedge mclk);
      end
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hs;
      htrans <= 2'h0;
      hwdata <= d;
      hs;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    begin
      bus(1'b0, a, 32'h00000000);
      chk(n, e, q);
      chk("hresp", 32'h00000000, {31'h0, hresp});
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // One-cycle event pulse, then let flags settle
  task pul(input logic [3:0] p, input logic [4:0] c);
    begin
      pls <= p;
      ch <= c;
      val <= 12'h12C;
      @(posedge mclk);
      pls <= 4'h0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // Output port check after settling
  task po(input string n, input logic [3:0] e);
    logic [3:0] g;
    begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      case (n)
        "irq": g = {3'h0, irq};
        "scan": g = {3'h0, scan};
        "disc": g = {3'h0, disc};
        "dpt": g = dpt;
        default: g = sync;
      endcase
      chk(n, {28'h0, e}, {28'h0, g});
      @(posedge mclk);
    end
  endtask
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    {rst_n, hsel, hwrite, peer} = 4'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h00000000;
    {pls, ch, val} = 21'h0;
    w0lo = 12'h064;
    w0hi = 12'h0C8;
    w1lo = 12'h190;
    w1hi = 12'hFFF;
    codes[0] = 4'h6;
    codes[1] = 4'h7;
    codes[2] = 4'h8;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h00000000, "status");
    rd(8'h04, 32'h00000000, "control");
    rd(8'h08, 32'h00000000, "unmapped");
    po("dpt", 4'h1);
    $display("reset test done");
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h4080EB60, "control");
    po("dpt", 4'h8);
    po("scan", 4'h1);
    po("disc", 4'h1);
    po("sync", 4'h0);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(8'h04, 32'h00000000);
      wr(8'h04, {12'h000, codes[i], 16'h0011});
      rd(8'h04, {12'h000, codes[i], 16'h0011}, "control");
      po("sync", codes[i]);
    end
    wr(8'h04, 32'h00000012);
    rd(8'h04, 32'h00000011, "chsel");
    $display("control test done");
    wr(8'h04, 32'h00000000);
    pul(4'h8, 5'h00);
    pul(4'h4, 5'h00);
    rd(8'h00, 32'h00000012, "status");
    po("irq", 4'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h00000012, "status");
    wr(8'h00, 32'h00000002);
    rd(8'h00, 32'h00000002, "status");
    pul(4'h2, 5'h00);
    rd(8'h00, 32'h00000000, "status");
    $display("flag test done");
    pul(4'h1, 5'h03);
    rd(8'h00, 32'h40000000, "status");
    wr(8'h00, 32'h00000000);
    wr(8'h04, 32'h00800205);
    pul(4'h1, 5'h03);
    rd(8'h00, 32'h40000000, "status");
    pul(4'h1, 5'h05);
    rd(8'h00, 32'h40000001, "status");
    $display("watchdog test done");
    wr(8'h04, 32'h00800245);
    po("irq", 4'h1);
    wr(8'h00, 32'h40000000);
    po("irq", 4'h0);
    wr(8'h04, 32'h40800265);
    po("irq", 4'h1);
    wr(8'h00, 32'h00000000);
    po("irq", 4'h0);
    pul(4'h4, 5'h00);
    po("irq", 4'h1);
    wr(8'h00, 32'h00000000);
    po("irq", 4'h0);
    peer <= 1'b1;
    po("irq", 4'h1);
    peer <= 1'b0;
    po("irq", 4'h0);
    $display("interrupt test done");
    // Sample inside a widened watchdog 1 window raises nothing
    w1lo <= 12'h064;
    pul(4'h1, 5'h03);
    rd(8'h00, 32'h00000000, "status");
    $display("window test done");
    finish_test;
  end
endmodule
bind adcsc_regs adcsc_regs_chk #(.IS_PRIMARY(IS_PRIMARY)) u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .peer_irq_i(peer_irq_i),
  .irq_o(irq_o), .scan_enable_o(scan_enable_o),
  .disc_enable_o(disc_enable_o),
  .disc_per_trigger_o(disc_per_trigger_o),
  .sync_select_o(sync_select_o));
`default_nettype wire
